//--- rtl/capture_compare_unit.sv
// sixteen-channel capture/compare unit with two reloadable timers and APB registers
//
// The APB register port and the address map were decided locally.
module capture_compare_unit (
    input  wire logic        i_clk_sys,
    input  wire logic        i_sys_rst,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic [15:0] i_pin,
    output logic      [15:0] o_pin,
    output logic      [15:0] o_pin_oe,
    input  wire logic        i_gpt_sixth_timer_overflow,
    input  wire logic [1:0]  i_ext_count,
    output logic             o_irq
);
    localparam int N    = capture_compare_unit_pkg::NUM_CH;
    localparam int TW   = capture_compare_unit_pkg::TMR_W;
    localparam int HALF = N / 2;

    logic [TW-1:0] tmr_reg   [2];
    logic [TW-1:0] rld_reg   [2];
    logic [TW-1:0] val_reg   [N];
    logic [7:0]    mode_reg  [N];
    logic [16:0]   tctl_reg;
    logic [17:0]   sts_reg;
    logic [17:0]   mask_reg;
    logic [7:0]    presc_reg;
    logic [1:0]    ext_q_reg;
    logic [2:0]    slot_reg;
    logic [31:0]   rdata_reg;
    logic          ready_reg;
    logic          err_reg;
    logic          irq_reg;
    logic [N-1:0]  pin_reg;
    logic [N-1:0]  oe_reg;

    // ---------------- bus decode ----------------
    wire        setup    = i_psel & ~i_penable;
    wire        access   = i_psel & i_penable & ready_reg;
    wire        wr       = access & i_pwrite;
    wire        rd       = access & ~i_pwrite;
    wire [1:0]  region   = i_paddr[7:6];
    wire [3:0]  ch_idx   = i_paddr[5:2];
    wire        in_val   = region == capture_compare_unit_pkg::REGION_VAL;
    wire        in_mode  = region == capture_compare_unit_pkg::REGION_MODE;
    wire        in_low   = region == 2'h0;
    wire        unmapped = (i_paddr[1:0] != 2'h0) | (region == 2'h3)
                         | (in_low & (i_paddr[5:0] > capture_compare_unit_pkg::OFS_MASK[5:0]));
    wire        wr_tmr0  = wr & (i_paddr == capture_compare_unit_pkg::OFS_TMR0);
    wire        wr_rld0  = wr & (i_paddr == capture_compare_unit_pkg::OFS_RLD0);
    wire        wr_tmr1  = wr & (i_paddr == capture_compare_unit_pkg::OFS_TMR1);
    wire        wr_rld1  = wr & (i_paddr == capture_compare_unit_pkg::OFS_RLD1);
    wire        wr_tctl  = wr & (i_paddr == capture_compare_unit_pkg::OFS_TCTL);
    wire        wr_mask  = wr & (i_paddr == capture_compare_unit_pkg::OFS_MASK);
    wire        rd_sts   = rd & (i_paddr == capture_compare_unit_pkg::OFS_STATUS);
    wire        stagger  = tctl_reg[capture_compare_unit_pkg::TCTL_STAGGER];

    logic [31:0] rmux;
    always_comb begin
        rmux = 32'h00000000;
        if (in_val) begin
            rmux = {16'h0000, val_reg[ch_idx]};
        end else if (in_mode) begin
            rmux = {24'h000000, mode_reg[ch_idx]};
        end else begin
            unique case (i_paddr)
                capture_compare_unit_pkg::OFS_TMR0:   rmux = {16'h0000, tmr_reg[0]};
                capture_compare_unit_pkg::OFS_RLD0:   rmux = {16'h0000, rld_reg[0]};
                capture_compare_unit_pkg::OFS_TMR1:   rmux = {16'h0000, tmr_reg[1]};
                capture_compare_unit_pkg::OFS_RLD1:   rmux = {16'h0000, rld_reg[1]};
                capture_compare_unit_pkg::OFS_TCTL:   rmux = {15'h0000, tctl_reg};
                capture_compare_unit_pkg::OFS_STATUS: rmux = {14'h0000, sts_reg};
                capture_compare_unit_pkg::OFS_MASK:   rmux = {14'h0000, mask_reg};
                default:                              rmux = 32'h00000000;
            endcase
        end
    end

    // no wait state: read data and ready are loaded in the setup cycle and leave straight from flops
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ready_reg <= 1'b0;
            err_reg   <= 1'b0;
            rdata_reg <= 32'h00000000;
        end else begin
            ready_reg <= setup;
            err_reg   <= setup & unmapped;
            rdata_reg <= (setup & ~i_pwrite & ~unmapped) ? rmux : 32'h00000000;
        end
    end

    // ---------------- count clock selection ----------------
    wire [1:0] ext_rise = i_ext_count & ~ext_q_reg;
    wire [1:0] ext_fall = ~i_ext_count & ext_q_reg;
    wire [1:0] tick;
    wire [1:0] tov;
    wire       tmr_wr [2];
    wire       rld_wr [2];
    assign tmr_wr[0] = wr_tmr0;
    assign tmr_wr[1] = wr_tmr1;
    assign rld_wr[0] = wr_rld0;
    assign rld_wr[1] = wr_rld1;

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            presc_reg <= 8'h00;
            ext_q_reg <= 2'h0;
            slot_reg  <= 3'h0;
        end else begin
            presc_reg <= presc_reg + 8'h01;
            ext_q_reg <= i_ext_count;
            slot_reg  <= slot_reg + 3'h1; // [R2]
        end
    end

    genvar t;
    generate
        for (t = 0; t < 2; t++) begin : g_tmr
            wire       run = tctl_reg[8*t + capture_compare_unit_pkg::TCTL_RUN];
            wire [2:0] sel = tctl_reg[8*t + capture_compare_unit_pkg::TCTL_SEL_LSB +: 3];
            logic      tk;
            always_comb begin
                unique case (sel)
                    capture_compare_unit_pkg::CK_DIV1:   tk = 1'b1; // [R1]
                    capture_compare_unit_pkg::CK_DIV4:   tk = &presc_reg[1:0]; // [R4]
                    capture_compare_unit_pkg::CK_DIV16:  tk = &presc_reg[3:0];
                    capture_compare_unit_pkg::CK_DIV64:  tk = &presc_reg[5:0];
                    capture_compare_unit_pkg::CK_DIV256: tk = &presc_reg;
                    capture_compare_unit_pkg::CK_GPT6:   tk = i_gpt_sixth_timer_overflow; // [R4]
                    capture_compare_unit_pkg::CK_EXTR:   tk = ext_rise[t]; // [R5]
                    capture_compare_unit_pkg::CK_EXTF:   tk = ext_fall[t]; // [R5]
                endcase
            end
            assign tick[t] = run & tk;
            assign tov[t]  = tick[t] & (tmr_reg[t] == capture_compare_unit_pkg::TMR_MAX);

            // software load wins over counting in the same cycle
            always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
                if (i_sys_rst) begin
                    tmr_reg[t] <= 16'h0000;
                    rld_reg[t] <= 16'h0000;
                end else begin
                    if (rld_wr[t]) begin
                        rld_reg[t] <= i_pwdata[TW-1:0]; // [R3]
                    end
                    if (tmr_wr[t]) begin
                        tmr_reg[t] <= i_pwdata[TW-1:0];
                    end else if (tov[t]) begin
                        tmr_reg[t] <= rld_reg[t]; // [R18]
                    end else if (tick[t]) begin
                        tmr_reg[t] <= tmr_reg[t] + 16'h0001; // [R3]
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            tctl_reg <= capture_compare_unit_pkg::TCTL_RST;
            mask_reg <= capture_compare_unit_pkg::MASK_RST;
        end else begin
            if (wr_tctl) begin
                tctl_reg <= i_pwdata[16:0];
            end
            if (wr_mask) begin
                mask_reg <= i_pwdata[17:0];
            end
        end
    end

    // ---------------- channel array ----------------
    wire [TW-1:0] ch_tv  [N];
    wire [N-1:0]  cap_ev;
    wire [N-1:0]  cmp_ev;
    wire [N-1:0]  val_wr;
    wire [N-1:0]  mode_wr;

    genvar c;
    generate
        for (c = 0; c < N; c++) begin : g_ch
            wire [2:0] md     = mode_reg[c][2:0];
            wire [1:0] edg    = mode_reg[c][capture_compare_unit_pkg::MD_EDGE_LSB +: 2];
            wire       tsel   = mode_reg[c][capture_compare_unit_pkg::MD_TSEL]; // [R6]
            wire       single = mode_reg[c][capture_compare_unit_pkg::MD_SINGLE];
            wire       tovc   = tsel ? tov[1] : tov[0];
            // staggered: each channel is looked at only in slot c mod 8, shared by two channels
            wire       act    = ~stagger | (slot_reg == 3'(c)); // [R2]
            logic      pin_q_reg;
            logic      eq_q_reg;
            logic      period_done_reg;
            logic      se_done_reg;
            wire       rise   = i_pin[c] & ~pin_q_reg;
            wire       fall   = ~i_pin[c] & pin_q_reg;
            wire       eq     = ch_tv[c] == val_reg[c];
            wire       is_cmp = (md == capture_compare_unit_pkg::CH_CMP0)
                              | (md == capture_compare_unit_pkg::CH_CMP1)
                              | (md == capture_compare_unit_pkg::CH_CMP2)
                              | (md == capture_compare_unit_pkg::CH_CMP3);
            wire       lim    = (md == capture_compare_unit_pkg::CH_CMP2)
                              | (md == capture_compare_unit_pkg::CH_CMP3);
            wire       partner;

            assign ch_tv[c]  = tsel ? tmr_reg[1] : tmr_reg[0];
            assign val_wr[c] = wr & in_val & (ch_idx == 4'(c));
            assign mode_wr[c] = wr & in_mode & (ch_idx == 4'(c));
            assign cap_ev[c] = act & (md == capture_compare_unit_pkg::CH_CAPT)
                             & ((edg[0] & rise) | (edg[1] & fall)); // [R8] [R10]
            // a match fires when the timer arrives at the value, not while it sits there
            assign cmp_ev[c] = act & is_cmp & eq & ~eq_q_reg // [R11] [R12]
                             & ~(lim & period_done_reg) // [R14] [R15]
                             & ~se_done_reg; // [R17]

            if (c < HALF) begin : g_dbl
                assign partner = mode_reg[c][capture_compare_unit_pkg::MD_DOUBLE]
                               & cmp_ev[c + HALF]; // [R16]
            end else begin : g_nodbl
                assign partner = 1'b0;
            end

            always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
                if (i_sys_rst) begin
                    pin_q_reg       <= 1'b0;
                    eq_q_reg        <= 1'b0;
                    period_done_reg <= 1'b0;
                    se_done_reg     <= 1'b0;
                end else begin
                    if (act) begin
                        pin_q_reg <= i_pin[c];
                        eq_q_reg  <= eq;
                    end
                    if (lim & cmp_ev[c]) begin
                        period_done_reg <= 1'b1;
                    end else if (tovc | mode_wr[c]) begin
                        period_done_reg <= 1'b0;
                    end
                    if (single & cmp_ev[c]) begin
                        se_done_reg <= 1'b1; // [R17]
                    end else if (mode_wr[c]) begin
                        se_done_reg <= 1'b0;
                    end
                end
            end

            // pin drive: output only while the channel compares
            always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
                if (i_sys_rst) begin
                    pin_reg[c] <= 1'b0;
                    oe_reg[c]  <= 1'b0;
                end else begin
                    oe_reg[c] <= is_cmp; // [R7]
                    if (md == capture_compare_unit_pkg::CH_CMP3) begin
                        if (cmp_ev[c]) begin
                            pin_reg[c] <= 1'b1; // [R15]
                        end else if (tovc) begin
                            pin_reg[c] <= 1'b0; // [R15]
                        end
                    end else if (((md == capture_compare_unit_pkg::CH_CMP1) & cmp_ev[c])
                                 ^ partner) begin
                        pin_reg[c] <= ~pin_reg[c]; // [R13] [R16]
                    end
                end
            end
        end
    endgenerate

    // capture wins over a software write to the same register
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            for (int i = 0; i < N; i++) begin
                val_reg[i]  <= 16'h0000;
                mode_reg[i] <= 8'h00;
            end
        end else begin
            for (int i = 0; i < N; i++) begin
                if (cap_ev[i]) begin
                    val_reg[i] <= ch_tv[i]; // [R8]
                end else if (val_wr[i]) begin
                    val_reg[i] <= i_pwdata[TW-1:0];
                end
                if (mode_wr[i]) begin
                    mode_reg[i] <= i_pwdata[7:0]; // [R6]
                end
            end
        end
    end

    // ---------------- interrupts ----------------
    wire [17:0] events   = {tov, cap_ev | cmp_ev}; // [R9] [R12] [R14] [R19]
    // clear only the bits the read returned: events after the setup snapshot survive
    wire [17:0] sts_next = (rd_sts ? (sts_reg & ~rdata_reg[17:0]) : sts_reg) | events;

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sts_reg <= 18'h00000;
            irq_reg <= 1'b0;
        end else begin
            sts_reg <= sts_next;
            irq_reg <= |(sts_next & mask_reg);
        end
    end

    assign o_prdata  = rdata_reg;
    assign o_pready  = ready_reg;
    assign o_pslverr = err_reg;
    assign o_pin     = pin_reg;
    assign o_pin_oe  = oe_reg;
    assign o_irq     = irq_reg;
endmodule : capture_compare_unit

//--- rtl/capture_compare_unit_pkg.sv
// constants and types of the sixteen-channel capture/compare unit
// Operation
// R1 - sixteen capture/compare channels, one system clock resolution normally
// R2 - staggered operation gives each channel one slot in eight cycles
// R3 - two independent 16-bit timers, each with its own reload register
// R4 - timer count clock from prescaled system clock or sixth timer overflow
// R5 - timers may also count external input events
// R6 - sixteen registers, each assignable to either timer, capture or compare
// R7 - each register owns one pin: capture input or compare output
// R8 - qualifying pin edge copies the assigned timer into the register
// R9 - every capture raises that channel's interrupt request
// R10 - capture edge per channel: rising, falling or both
// R11 - compare channels compare continuously; a match runs the mode's action
// R12 - compare mode 0: interrupt only, pin untouched, many per period
// R13 - compare mode 1: every match toggles the pin, many per period
// R14 - compare mode 2: interrupt only, at most one per timer period
// R15 - compare mode 3: match sets pin, overflow clears it, one per period
// R16 - double register: two channels toggle one shared pin on either match
// R17 - single-event option limits a compare channel to one event
// R18 - timer overflow reloads the count from its reload register
// R19 - matches in modes 1 and 3 also set the channel interrupt flag
package capture_compare_unit_pkg;
    localparam int          NUM_CH       = 16;
    localparam int          TMR_W        = 16;
    localparam logic [7:0]  OFS_TMR0     = 8'h00;
    localparam logic [7:0]  OFS_RLD0     = 8'h04;
    localparam logic [7:0]  OFS_TMR1     = 8'h08;
    localparam logic [7:0]  OFS_RLD1     = 8'h0c;
    localparam logic [7:0]  OFS_TCTL     = 8'h10;
    localparam logic [7:0]  OFS_STATUS   = 8'h14;
    localparam logic [7:0]  OFS_MASK     = 8'h18;
    localparam logic [1:0]  REGION_VAL   = 2'h1;
    localparam logic [1:0]  REGION_MODE  = 2'h2;
    // timer control: 8 bits per timer, stagger above
    localparam int          TCTL_RUN     = 0;
    localparam int          TCTL_SEL_LSB = 1;
    localparam int          TCTL_STAGGER = 16;
    localparam int          STS_TOV_LSB  = 16;
    // channel mode register fields
    localparam int          MD_EDGE_LSB  = 3;
    localparam int          MD_TSEL      = 5;
    localparam int          MD_SINGLE    = 6;
    localparam int          MD_DOUBLE    = 7;
    localparam logic [16:0] TCTL_RST     = 17'h00000;
    localparam logic [17:0] MASK_RST     = 18'h00000;
    localparam logic [15:0] TMR_MAX      = 16'hffff;
    localparam logic [2:0]  STAGGER_LAST = 3'h7;

    typedef enum logic [2:0] {
        CH_OFF  = 3'b000,
        CH_CAPT = 3'b001,
        CH_CMP0 = 3'b010,
        CH_CMP1 = 3'b011,
        CH_CMP2 = 3'b100,
        CH_CMP3 = 3'b101
    } ch_mode_t;

    typedef enum logic [2:0] {
        CK_DIV1  = 3'b000,
        CK_DIV4  = 3'b001,
        CK_DIV16 = 3'b010,
        CK_DIV64 = 3'b011,
        CK_DIV256 = 3'b100,
        CK_GPT6  = 3'b101,
        CK_EXTR  = 3'b110,
        CK_EXTF  = 3'b111
    } clk_sel_t;
endpackage : capture_compare_unit_pkg

//--- testbench/cc_properties.sv
// port-level timing checks of the capture/compare unit
module cc_properties (
    input wire logic        i_clk_sys,
    input wire logic        i_sys_rst,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [7:0]  i_paddr,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    input wire logic [15:0] o_pin_oe,
    input wire logic        o_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_sys_rst);
    wire setup  = i_psel && !i_penable;
    wire wr_acc = i_psel && i_penable && i_pwrite && o_pready;

    property p_ready_delay;
        setup |=> o_pready;
    endproperty
    a_ready_delay: assert property (p_ready_delay) else $error("pready not one cycle after setup");
    property p_ready_pulse;
        o_pready |=> !o_pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
    property p_err_only;
        o_pslverr |-> o_pready;
    endproperty
    a_err_only: assert property (p_err_only) else $error("pslverr without pready");
    property p_rdata_idle;
        !o_pready |-> o_prdata == 32'h00000000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside access");
    property p_misalign;
        setup && i_paddr[1:0] != 2'h0 |=> o_pslverr && o_prdata == 32'h00000000;
    endproperty
    a_misalign: assert property (p_misalign) else $error("misaligned access not refused");
    property p_unmapped;
        setup && i_paddr >= 8'hc0 |=> o_pslverr;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    property p_width;
        o_pready |-> o_prdata[31:18] == 14'h0000;
    endproperty
    a_width: assert property (p_width) else $error("unused read bits set");
    // output enables follow mode writes only, never pin activity
    property p_oe_cause;
        $changed(o_pin_oe) |-> $past(wr_acc) || $past(wr_acc, 2);
    endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("pin enable moved without write");
    property p_reset_quiet;
        $fell(i_sys_rst) |-> o_pin_oe == 16'h0000 && !o_irq && !o_pready;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");

    c_refused: cover property (setup ##1 o_pslverr);
    c_irq: cover property ($rose(o_irq));
    c_oe: cover property ($changed(o_pin_oe));
endmodule : cc_properties

bind capture_compare_unit cc_properties cc_properties_i (.i_clk_sys, .i_sys_rst, .i_psel,
    .i_penable, .i_pwrite, .i_paddr, .o_prdata, .o_pready, .o_pslverr, .o_pin_oe, .o_irq);

//--- testbench/pin_side_model.sv
// external pins: channel levels, sixth timer overflow pulses, count inputs
module pin_side_model (
    input  wire logic        i_clk_sys,
    input  wire logic        i_sys_rst,
    input  wire logic [15:0] i_level,
    input  wire logic        i_tick,
    input  wire logic [1:0]  i_flip,
    output logic      [15:0] o_level,
    output logic             o_ovf,
    output logic      [1:0]  o_ext
);
    timeunit 1ns;
    timeprecision 1ps;
    // registered so every pin change lands just after a clock edge
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_level <= 16'h0000;
            o_ovf   <= 1'b0;
            o_ext   <= 2'h0;
        end else begin
            o_level <= i_level;
            o_ovf   <= i_tick;
            o_ext   <= o_ext ^ i_flip;
        end
    end
endmodule : pin_side_model

//--- testbench/tb.sv
// self-checking bench for the capture/compare unit
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] sts = capture_compare_unit_pkg::OFS_STATUS;
    localparam logic [7:0] tm0 = capture_compare_unit_pkg::OFS_TMR0;
    localparam logic [7:0] tct = capture_compare_unit_pkg::OFS_TCTL;
    logic        clk     = 1'b0;
    logic        rst     = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic        tick    = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h00000000;
    logic [15:0] level   = 16'h0000;
    logic [1:0]  flip    = 2'h0;
    logic [31:0] prdata, rdata;
    logic        pready, pslverr, irq, ovf, err;
    logic [15:0] pin_out, pin_oe, model_pin, pin_wire;
    logic [1:0]  ext;
    int          mismatches  = 0;
    int          check_count = 0;

    always #12.5 clk = ~clk;
    // a driven compare pin overrides the outside level
    assign pin_wire = (pin_out & pin_oe) | (model_pin & ~pin_oe);

    capture_compare_unit capture_compare_unit_i (.i_clk_sys(clk), .i_sys_rst(rst),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_pin(pin_wire), .o_pin(pin_out), .o_pin_oe(pin_oe),
        .i_gpt_sixth_timer_overflow(ovf), .i_ext_count(ext), .o_irq(irq));
    pin_side_model pin_side_model_i (.i_clk_sys(clk), .i_sys_rst(rst), .i_level(level),
        .i_tick(tick), .i_flip(flip), .o_level(model_pin), .o_ovf(ovf), .o_ext(ext));

    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rdata = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            mismatches++;
            end_sim();
        end
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(rdata, exp);
    endtask : rd

    // one timer tick per overflow pulse of the sixth timer
    task automatic tk(input int n);
        repeat (n) begin
            @(posedge clk);
            tick <= 1'b1;
            @(posedge clk);
            tick <= 1'b0;
        end
        cyc(3);
    endtask : tk

    initial begin
        cyc(6);
        rst <= 1'b0;
        rd(tct, 32'h00000000);
        rd(capture_compare_unit_pkg::OFS_MASK, 32'h00000000);
        wr(tm0, 32'h0000fffe);
        wr(capture_compare_unit_pkg::OFS_RLD0, 32'h0000fff0);
        wr(tct, 32'h00001d0b);
        rd(tct, 32'h00001d0b);
        tk(3);
        rd(tm0, 32'h0000fff1);
        rd(sts, 32'h00010000);
        rd(sts, 32'h00000000);
        repeat (4) begin
            @(posedge clk);
            flip <= 2'h2;
            @(posedge clk);
            flip <= 2'h0;
        end
        cyc(3);
        rd(capture_compare_unit_pkg::OFS_TMR1, 32'h00000002);
        // channels 0..2: rising, falling, both edges
        for (int k = 0; k < 3; k++) wr(8'h80 + 8'(k * 4), 32'(1 + (k + 1) * 8));
        level <= 16'h0007;
        cyc(4);
        tk(1);
        level <= 16'h0000;
        cyc(4);
        rd(8'h40, 32'h0000fff1);
        rd(8'h44, 32'h0000fff2);
        rd(8'h48, 32'h0000fff2);
        wr(capture_compare_unit_pkg::OFS_MASK, 32'h00000001);
        cyc(2);
        chk(32'(irq), 32'h1);
        rd(sts, 32'h00000007);
        cyc(2);
        chk(32'(irq), 32'h0);
        // channels 4..7 in compare modes 0..3, all matching at fff4
        for (int k = 0; k < 4; k++) begin
            wr(8'h50 + 8'(k * 4), 32'h0000fff4);
            wr(8'h90 + 8'(k * 4), 32'(2 + k));
        end
        wr(8'h4c, 32'h0000fff6);
        wr(8'h8c, 32'h00000083);
        wr(8'h6c, 32'h0000fff8);
        wr(8'hac, 32'h00000002);
        wr(8'h70, 32'h0000fff5);
        wr(8'hb0, 32'h00000043);
        cyc(2);
        chk(32'(pin_oe), 32'h000018f8);
        rd(sts, 32'h00000000);
        tk(2);
        rd(sts, 32'h000000f0);
        chk(32'(pin_out[7:4]), 32'ha);
        wr(tm0, 32'h0000fff3);
        tk(1);
        rd(sts, 32'h00000030);
        chk(32'(pin_out[7:4]), 32'h8);
        tk(11);
        rd(sts, 32'h00001808);
        chk(32'({pin_out[12], pin_out[3]}), 32'h2);
        tk(1);
        chk(32'(pin_out[7]), 32'h0);
        tk(8);
        rd(sts, 32'h000108f8);
        chk(32'(pin_out[12]), 32'h1);
        // staggered, timers held: a falling edge on channel 1 still captures in its slot
        wr(tct, 32'h00010000);
        level <= 16'h0002;
        cyc(10);
        level <= 16'h0000;
        cyc(10);
        rd(8'h44, 32'h0000fff8);
        rd(sts, 32'h00000002);
        apb(1'b0, 8'h1c, 32'h00000000);
        chk(32'({err, rdata[30:0]}), 32'h80000000);
        apb(1'b1, 8'h02, 32'h0000ffff);
        chk(32'(err), 32'h1);
        end_sim();
    end
endmodule : tb
